// *** hdl/pct_timer_regs.svh ***
`ifndef PCT_TIMER_REGS_SVH
`define PCT_TIMER_REGS_SVH
// ==========================================
// Register byte offsets
`define PCT_OFF_CTRL 8'h00
`define PCT_OFF_SMODE 8'h04
`define PCT_OFF_CHCFG 8'h08
`define PCT_OFF_STAT 8'h0C
`define PCT_OFF_MASK 8'h10
`define PCT_OFF_CNT 8'h14
`define PCT_OFF_PSC 8'h18
`define PCT_OFF_ARR 8'h1C
`define PCT_OFF_CCR0 8'h20
`define PCT_OFF_CCR3 8'h2C
`define PCT_OFF_DT 8'h30
// ==========================================
// Field positions and widths
`define PCT_STAT_UPD 0
`define PCT_STAT_CC 1
`define PCT_STAT_TRG 5
`define PCT_STAT_W 6
`define PCT_CTRL_HWDIR 8
`define PCT_PSC_W 16
`define PCT_DT_W 8
// ==========================================
// Reset values and bus answers
`define PCT_RST_ZERO 32'h0000_0000
`define PCT_RST_ARR 32'hFFFF_FFFF
`define PCT_RESP_OKAY 2'h0
`define PCT_RESP_SLVERR 2'h2
`endif

// *** hdl/pct_pkg.sv ***
// ==========================================
// Types of the capture and PWM timer
package pct_pkg;
   typedef enum logic [1:0] {
      PCT_CH_CMP = 2'h0,
      PCT_CH_PWM = 2'h1,
      PCT_CH_CAP = 2'h3
   } pct_chmode_e;
   typedef enum logic [2:0] {
      PCT_SM_FREE = 3'h0,
      PCT_SM_TRIG = 3'h1,
      PCT_SM_GATED = 3'h3,
      PCT_SM_EXTCLK = 3'h2,
      PCT_SM_ENC = 3'h6
   } pct_smode_e;
   typedef struct packed {logic spm; logic cms; logic dir; logic cen;} pct_ctrl_s;
   typedef struct packed {logic oen; logic [1:0] cap_edge; pct_chmode_e mode;} pct_chcfg_s;
   typedef struct packed {logic tsel; pct_smode_e mode;} pct_smode_s;
endpackage : pct_pkg

// *** hdl/pct_timer.sv ***
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "pct_timer_regs.svh"
// ==========================================
// Summary of operation
// - Wide variant: 32-bit up/down auto-reload counter, 16-bit prescaler.
// - Narrow bidirectional variant: 16-bit up/down counter, 16-bit prescaler.
// - Basic variants: 16-bit up-only counter, 16-bit prescaler; encoder mode still counts down here.
// - Four channels, each set for PWM, compare or capture.
// - External trigger input can start or clock the counter.
// - Encoder mode decodes two quadrature inputs into direction and count.
// - Advanced variant inserts dead-time between an output and its complement.
// - Advanced variant drives three complementary pairs, six lines.
// - PWM is edge-aligned or center-aligned by configuration.
// - Single-pulse mode stops the counter after one period.
// - Advanced variant as plain timer behaves like the general timers; here ch_out[2:0] rise one cycle later even at dead-time 0.
// - Timers synchronise to external signals and trigger or gate each other.
// - Capture on input edges measures pulse width.
module pct_timer #(
   parameter int CNT_W = 16,      // Counter width, 32 on the wide variant
   parameter bit HAS_DOWN = 1'b1, // Down and center counting present
   parameter bit HAS_CMPL = 1'b1  // Complementary outputs present
) (
   input wire logic aclk,         // Clock
   input wire logic aresetn,      // Sync reset, active low
   input wire logic [7:0] awaddr, // Write address
   input wire logic awvalid,      // Write address valid
   output logic awready,          // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb,  // Write byte strobes
   input wire logic wvalid,       // Write data valid
   output logic wready,           // Write data ready
   output logic [1:0] bresp,      // Write response
   output logic bvalid,           // Write response valid
   input wire logic bready,       // Write response ready
   input wire logic [7:0] araddr, // Read address
   input wire logic arvalid,      // Read address valid
   output logic arready,          // Read address ready
   output logic [31:0] rdata,     // Read data
   output logic [1:0] rresp,      // Read response
   output logic rvalid,           // Read data valid
   input wire logic rready,       // Read data ready
   input wire logic [3:0] ch_in,  // Channel pins, input side
   output logic [3:0] ch_out,     // Channel pins, output side
   output logic [3:0] ch_oe,      // Channel pins, drive enable
   output logic [2:0] chn_out,    // Complementary outputs
   output logic [2:0] chn_oe,     // Complementary drive enable
   input wire logic etr_in,       // External trigger pin
   input wire logic trg_in,       // Trigger from another timer
   output logic trg_out,          // Update pulse to other timers
   output logic irq               // Interrupt level
);
   import pct_pkg::*;

   localparam logic [31:0] ARR_RST = `PCT_RST_ARR;
   localparam int SW = `PCT_STAT_W;
   localparam int DW = `PCT_DT_W;
   localparam int PW = `PCT_PSC_W;

   logic [4:0] sy1_ff, sy2_ff, sp_ff;
   logic trp_ff;
   pct_ctrl_s ctrl_ff, nxt_ctrl;
   pct_smode_s smode_ff, nxt_smode;
   pct_chcfg_s [3:0] chcfg_ff, nxt_chcfg;
   logic [SW-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask, ev;
   logic [PW-1:0] psc_ff, nxt_psc, pscc_ff, nxt_pscc;
   logic [DW-1:0] dt_ff, nxt_dt;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt, arr_ff, nxt_arr;
   logic [CNT_W-1:0] ccr_ff [4];
   logic [CNT_W-1:0] nxt_ccr [4];
   logic hdir_ff, nxt_hdir, trgo_ff, nxt_trgo, irq_ff, nxt_irq;
   logic [3:0] ref_ff, nxt_ref, refd_ff, p_ff, nxt_p;
   logic [2:0] n_ff, nxt_n;
   logic [DW-1:0] dtc_ff [3];
   logic [DW-1:0] nxt_dtc [3];
   logic tick, upd, trg_lvl, trg_rise, enc, center, dn, src, hit;
   logic rise, fall;
   logic [CNT_W:0] sv;
   logic [31:0] wv, wc;
   logic aw_ok_ff, nxt_awok, w_ok_ff, nxt_wok, do_wr;
   logic [7:0] awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd, rdata_ff, nxt_rdata;
   logic [3:0] ws_ff, nxt_ws;
   logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

   // ==========================================
   // Helper functions
   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : wmerge

   // Address decode, aligned and inside the map
   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `PCT_OFF_DT);
   endfunction : mapped

   // Register read view
   function automatic logic [31:0] rdmux(input logic [7:0] a);
      logic [31:0] r;
      r = `PCT_RST_ZERO;
      if (a == `PCT_OFF_CTRL) begin
         r[3:0] = ctrl_ff;
         r[`PCT_CTRL_HWDIR] = hdir_ff;
      end else if (a == `PCT_OFF_SMODE) begin
         r[3:0] = smode_ff;
      end else if (a == `PCT_OFF_CHCFG) begin
         for (int j = 0; j < 4; j++) begin
            r[8*j +: 5] = chcfg_ff[j];
         end
      end else if (a == `PCT_OFF_STAT) begin
         r[SW-1:0] = stat_ff;
      end else if (a == `PCT_OFF_MASK) begin
         r[SW-1:0] = mask_ff;
      end else if (a == `PCT_OFF_CNT) begin
         r[CNT_W-1:0] = cnt_ff;
      end else if (a == `PCT_OFF_PSC) begin
         r[PW-1:0] = psc_ff;
      end else if (a == `PCT_OFF_ARR) begin
         r[CNT_W-1:0] = arr_ff;
      end else if (a == `PCT_OFF_DT) begin
         r[DW-1:0] = dt_ff;
      end else if (a >= `PCT_OFF_CCR0 && a <= `PCT_OFF_CCR3 && a[1:0] == 2'h0) begin
         r[CNT_W-1:0] = ccr_ff[a[3:2]];
      end
      return r;
   endfunction : rdmux

   // One counting step with wrap flag on top
   function automatic logic [CNT_W:0] step(input logic [CNT_W-1:0] c,
                                           input logic [CNT_W-1:0] top, input logic down);
      if (down) begin
         return (c == '0) ? {1'b1, top} : {1'b0, c - 1'b1};
      end
      return (c >= top) ? {1'b1, {CNT_W{1'b0}}} : {1'b0, c + 1'b1};
   endfunction : step

   // ==========================================
   // AXI4-Lite slave handshake
   assign awready = ~aw_ok_ff & ~bvalid_ff;
   assign wready = ~w_ok_ff & ~bvalid_ff;
   assign arready = ~rvalid_ff;
   assign do_wr = aw_ok_ff & w_ok_ff & ~bvalid_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   // Next state of the bus channels
   always_comb begin
      nxt_awok = aw_ok_ff;
      nxt_wok = w_ok_ff;
      nxt_awa = awa_ff;
      nxt_wd = wd_ff;
      nxt_ws = ws_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (awvalid && awready) begin
         nxt_awok = 1'b1;
         nxt_awa = awaddr;
      end
      if (wvalid && wready) begin
         nxt_wok = 1'b1;
         nxt_wd = wdata;
         nxt_ws = wstrb;
      end
      if (do_wr) begin
         nxt_awok = 1'b0;
         nxt_wok = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = mapped(awa_ff) ? `PCT_RESP_OKAY : `PCT_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = rdmux(araddr);
         nxt_rresp = mapped(araddr) ? `PCT_RESP_OKAY : `PCT_RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   // ==========================================
   // Timer core: prescaler, counter, channels, registers
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_smode = smode_ff;
      nxt_chcfg = chcfg_ff;
      nxt_mask = mask_ff;
      nxt_psc = psc_ff;
      nxt_dt = dt_ff;
      nxt_arr = arr_ff;
      nxt_ccr = ccr_ff;
      nxt_cnt = cnt_ff;
      nxt_pscc = pscc_ff;
      nxt_hdir = hdir_ff;
      nxt_ref = ref_ff;
      nxt_stat = stat_ff;
      ev = '0;
      tick = 1'b0;
      upd = 1'b0;
      sv = '0;
      wv = `PCT_RST_ZERO;
      wc = `PCT_RST_ZERO;
      rise = 1'b0;
      fall = 1'b0;
      hit = 1'b0;
      trg_lvl = smode_ff.tsel ? trg_in : sy2_ff[4];
      trg_rise = trg_lvl & ~trp_ff;
      enc = (smode_ff.mode == PCT_SM_ENC);
      center = ctrl_ff.cms & HAS_DOWN;
      dn = center ? hdir_ff : (ctrl_ff.dir & HAS_DOWN);
      // Clock source and prescaler
      case (smode_ff.mode)
         PCT_SM_EXTCLK: src = trg_rise;
         PCT_SM_GATED: src = trg_lvl;
         PCT_SM_ENC: src = 1'b0;
         default: src = 1'b1;
      endcase
      if (ctrl_ff.cen && src) begin
         if (pscc_ff >= psc_ff) begin
            nxt_pscc = '0;
            tick = 1'b1;
         end else begin
            nxt_pscc = pscc_ff + 16'h0001;
         end
      end
      // Counter step, reload and center turnaround
      if (tick) begin
         sv = step(cnt_ff, arr_ff, dn);
         upd = sv[CNT_W];
         nxt_hdir = dn;
         if (center && upd) begin
            nxt_hdir = ~dn;
            sv = step(cnt_ff, arr_ff, ~dn);
         end
         nxt_cnt = sv[CNT_W-1:0];
      end
      // Quadrature decode, one step per single-input change
      if (enc && ctrl_ff.cen && ((sy2_ff[0] ^ sp_ff[0]) ^ (sy2_ff[1] ^ sp_ff[1]))) begin
         sv = step(cnt_ff, arr_ff, ~(sy2_ff[0] ^ sp_ff[1]));
         upd = sv[CNT_W];
         nxt_hdir = ~(sy2_ff[0] ^ sp_ff[1]);
         nxt_cnt = sv[CNT_W-1:0];
      end
      // Update and trigger events
      if (upd) begin
         ev[`PCT_STAT_UPD] = 1'b1;
         if (ctrl_ff.spm) begin
            nxt_ctrl.cen = 1'b0;
         end
      end
      if (trg_rise) begin
         ev[`PCT_STAT_TRG] = 1'b1;
         if (smode_ff.mode == PCT_SM_TRIG) begin
            nxt_ctrl.cen = 1'b1;
         end
      end
      // Register writes
      if (do_wr) begin
         wv = wmerge(rdmux(awa_ff), wd_ff, ws_ff);
         wc = wmerge(`PCT_RST_ZERO, wd_ff, ws_ff);
         if (awa_ff == `PCT_OFF_CTRL) begin
            nxt_ctrl = pct_ctrl_s'(wv[3:0]);
         end else if (awa_ff == `PCT_OFF_SMODE) begin
            nxt_smode = pct_smode_s'(wv[3:0]);
         end else if (awa_ff == `PCT_OFF_CHCFG) begin
            for (int j = 0; j < 4; j++) begin
               nxt_chcfg[j] = pct_chcfg_s'(wv[8*j +: 5]);
            end
         end else if (awa_ff == `PCT_OFF_STAT) begin
            nxt_stat = stat_ff & ~wc[SW-1:0];
         end else if (awa_ff == `PCT_OFF_MASK) begin
            nxt_mask = wv[SW-1:0];
         end else if (awa_ff == `PCT_OFF_CNT) begin
            nxt_cnt = wv[CNT_W-1:0];
         end else if (awa_ff == `PCT_OFF_PSC) begin
            nxt_psc = wv[PW-1:0];
         end else if (awa_ff == `PCT_OFF_ARR) begin
            nxt_arr = wv[CNT_W-1:0];
         end else if (awa_ff == `PCT_OFF_DT) begin
            nxt_dt = wv[DW-1:0];
         end else if (mapped(awa_ff) && awa_ff >= `PCT_OFF_CCR0) begin
            nxt_ccr[awa_ff[3:2]] = wv[CNT_W-1:0];
         end
      end
      // Channels: capture, compare, PWM
      for (int i = 0; i < 4; i++) begin
         rise = sy2_ff[i] & ~sp_ff[i];
         fall = ~sy2_ff[i] & sp_ff[i];
         if (chcfg_ff[i].mode == PCT_CH_CAP) begin
            hit = chcfg_ff[i].cap_edge[1] ? (rise | fall)
                  : (chcfg_ff[i].cap_edge[0] ? fall : rise);
            if (hit) begin
               nxt_ccr[i] = cnt_ff;
               ev[`PCT_STAT_CC + i] = 1'b1;
            end
         end else begin
            if (tick && cnt_ff == ccr_ff[i]) begin
               ev[`PCT_STAT_CC + i] = 1'b1;
               if (chcfg_ff[i].mode == PCT_CH_CMP) begin
                  nxt_ref[i] = ~ref_ff[i];
               end
            end
            if (chcfg_ff[i].mode == PCT_CH_PWM) begin
               nxt_ref[i] = (cnt_ff < ccr_ff[i]);
            end
         end
      end
      // Flags: hardware set wins over software clear
      nxt_stat = nxt_stat | ev;
      nxt_irq = |(nxt_stat & nxt_mask);
      nxt_trgo = upd;
   end

   // ==========================================
   // Dead-time insertion on the complementary pairs
   always_comb begin
      nxt_dtc = dtc_ff;
      nxt_p = p_ff;
      nxt_n = n_ff;
      nxt_p[3] = ref_ff[3];
      for (int i = 0; i < 3; i++) begin
         if (!HAS_CMPL) begin
            nxt_p[i] = ref_ff[i];
            nxt_n[i] = 1'b0;
         end else if (ref_ff[i] != refd_ff[i]) begin
            nxt_dtc[i] = dt_ff;
            nxt_p[i] = 1'b0;
            nxt_n[i] = 1'b0;
         end else if (dtc_ff[i] != '0) begin
            nxt_dtc[i] = dtc_ff[i] - 8'h01;
         end else begin
            nxt_p[i] = ref_ff[i];
            nxt_n[i] = ~ref_ff[i];
         end
      end
   end

   // Pin drive enables follow channel configuration
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ch_oe[i] = chcfg_ff[i].oen & (chcfg_ff[i].mode != PCT_CH_CAP);
      end
      chn_oe = HAS_CMPL ? ch_oe[2:0] : 3'h0;
   end
   assign ch_out = p_ff;
   assign chn_out = n_ff;
   assign trg_out = trgo_ff;
   assign irq = irq_ff;

   // ==========================================
   // State registers
   always_ff @(posedge aclk) begin
      sy1_ff <= {etr_in, ch_in};
      sy2_ff <= sy1_ff;
      if (!aresetn) begin
         sp_ff <= '0;
         trp_ff <= 1'b0;
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awa_ff <= 8'h00;
         wd_ff <= `PCT_RST_ZERO;
         ws_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `PCT_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= `PCT_RST_ZERO;
         rresp_ff <= `PCT_RESP_OKAY;
         ctrl_ff <= '0;
         smode_ff <= '0;
         chcfg_ff <= '0;
         stat_ff <= '0;
         mask_ff <= '0;
         psc_ff <= '0;
         pscc_ff <= '0;
         dt_ff <= '0;
         cnt_ff <= '0;
         arr_ff <= ARR_RST[CNT_W-1:0];
         ccr_ff <= '{default: '0};
         hdir_ff <= 1'b0;
         trgo_ff <= 1'b0;
         irq_ff <= 1'b0;
         ref_ff <= 4'h0;
         refd_ff <= 4'h0;
         p_ff <= 4'h0;
         n_ff <= 3'h0;
         dtc_ff <= '{default: '0};
      end else begin
         sp_ff <= sy2_ff;
         trp_ff <= trg_lvl;
         aw_ok_ff <= nxt_awok;
         w_ok_ff <= nxt_wok;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         ws_ff <= nxt_ws;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         ctrl_ff <= nxt_ctrl;
         smode_ff <= nxt_smode;
         chcfg_ff <= nxt_chcfg;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         psc_ff <= nxt_psc;
         pscc_ff <= nxt_pscc;
         dt_ff <= nxt_dt;
         cnt_ff <= nxt_cnt;
         arr_ff <= nxt_arr;
         ccr_ff <= nxt_ccr;
         hdir_ff <= nxt_hdir;
         trgo_ff <= nxt_trgo;
         irq_ff <= nxt_irq;
         ref_ff <= nxt_ref;
         refd_ff <= ref_ff;
         p_ff <= nxt_p;
         n_ff <= nxt_n;
         dtc_ff <= nxt_dtc;
      end
   end
endmodule : pct_timer
`default_nettype wire

// *** tb/pct_timer_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checker of the capture and PWM timer
module pct_timer_chk (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset
   input wire logic awvalid, // Addr valid
   input wire logic awready, // Addr ready
   input wire logic wvalid, // Data valid
   input wire logic wready, // Data ready
   input wire logic bvalid, // Resp valid
   input wire logic arvalid, // Read valid
   input wire logic arready, // Read ready
   input wire logic [31:0] rdata, // Read data
   input wire logic rvalid, // Data valid
   input wire logic rready, // Data ready
   input wire logic [3:0] ch_out, // Outputs
   input wire logic [3:0] ch_oe, // Enables
   input wire logic [2:0] chn_out, // Pair outputs
   input wire logic [2:0] chn_oe, // Pair enables
   input wire logic trg_out, // Update pulse
   input wire logic irq // Interrupt
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Bus steps
   sequence s_wr_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wr_ans;
      ##[1:2] bvalid;
   endsequence
   property p_wr_answer;
      s_wr_take |-> s_wr_ans;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
   property p_rd_answer;
      arvalid && arready |=> rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   // ==========================================
   // Pin relations
   property p_no_overlap;
      (ch_out[2:0] & chn_out[2:0]) == 3'h0;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("pair both high");
   property p_dead_gap;
      $rose(ch_out[0]) |-> !$past(chn_out[0]);
   endproperty
   a_dead_gap: assert property (p_dead_gap) else $error("no gap before output");
   property p_dead_gap_n;
      $rose(chn_out[1]) |-> !$past(ch_out[1]);
   endproperty
   a_dead_gap_n: assert property (p_dead_gap_n) else $error("no gap before pair");
   property p_pair_oe;
      chn_oe == ch_oe[2:0];
   endproperty
   a_pair_oe: assert property (p_pair_oe) else $error("pair enable differs");
   property p_reset_quiet;
      $rose(aresetn) |-> !trg_out && !irq && ch_out == 4'h0 && chn_out == 3'h0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule : pct_timer_chk
bind pct_timer pct_timer_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .ch_out(ch_out),
   .ch_oe(ch_oe), .chn_out(chn_out), .chn_oe(chn_oe), .trg_out(trg_out), .irq(irq));
`default_nettype wire

// *** tb/pct_field_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Pin-side signal source
module pct_field_model (
   input wire logic aclk, // Clock
   output logic [3:0] src, // Channel drive
   output logic etr_in // Trigger drive
);
   // Idle levels
   initial begin
      src = 4'h0;
      etr_in = 1'b0;
   end
   // One high pulse on channel 0
   task automatic pulse(input int w);
      @(posedge aclk);
      src[0] <= 1'b1;
      repeat (w) @(posedge aclk);
      src[0] <= 1'b0;
   endtask : pulse
   // Quadrature steps, one input changing at a time
   task automatic quad(input int n, input bit back);
      repeat (n) begin
         @(posedge aclk);
         if ((src[0] == src[1]) ^ back) src[0] <= ~src[0];
         else src[1] <= ~src[1];
         repeat (7) @(posedge aclk);
      end
   endtask : quad
   // Short trigger pulse
   task automatic kick();
      @(posedge aclk);
      etr_in <= 1'b1;
      repeat (4) @(posedge aclk);
      etr_in <= 1'b0;
   endtask : kick
endmodule : pct_field_model
`default_nettype wire

// *** tb/pct_timer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pct_timer_regs.svh"
// ==========================================
// Self-checking bench of the capture and PWM timer
module pct_timer_tb;
   import pct_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, trg_in, trg_out, irq, etr_in;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv, psc;
   logic [3:0] wstrb, ch_out, ch_oe, src;
   logic [2:0] chn_out, chn_oe;
   logic [1:0] bresp, rresp;
   wire logic [3:0] ch_in;
   logic [34:0] rq[$];
   logic [1:0] bq[$];
   int bad_count, cmp_count, cyc, last, hi, lo, w, armed, tq[$];
   pct_timer uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe), .chn_out(chn_out), .chn_oe(chn_oe),
      .etr_in(etr_in), .trg_in(trg_in), .trg_out(trg_out), .irq(irq));
   pct_field_model pm (.aclk(aclk), .src(src), .etr_in(etr_in));
   // Pin level from both drivers
   assign ch_in = (ch_oe & ch_out) | (~ch_oe & src);
   // Clock
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // ==========================================
   // Compare, report and bus tasks
   task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_bus
   task automatic chk_pin(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_pin
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      @(posedge aclk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0,
                     input bit skip = 1'b0);
      @(posedge aclk);
      rq.push_back({skip, r, e});
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      rdv = rdata;
      rready <= 1'b0;
   endtask : rd
   // Result watcher and run limit
   always @(posedge aclk) begin
      cyc++;
      if (bvalid && bready) chk_bus({32'h0, bq.pop_front()}, {32'h0, bresp});
      if (rvalid && rready) begin
         chk_bus(rq[0][33:0], {rresp, rq[0][34] ? rq[0][31:0] : rdata});
         void'(rq.pop_front());
      end
      if (tq.size() == 0) armed = 1'b0;
      else if (trg_out) begin
         if (armed) chk_pin(tq.pop_front(), cyc - last);
         armed = 1'b1;
         last = cyc;
      end
      if (cyc > 40000) begin
         bad_count++;
         close_out();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, trg_in, awaddr, araddr, wstrb, wdata} = '0;
      void'($urandom(38755));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`PCT_OFF_CTRL, 32'h0);
      rd(`PCT_OFF_ARR, 32'h0000_FFFF);
      rd(8'h40, 32'h0, `PCT_RESP_SLVERR);
      wr(8'h40, 32'h1, `PCT_RESP_SLVERR);
      // Update period: up, down, centre, random prescale
      for (int i = 0; i < 4; i++) begin
         psc = (i == 3) ? $urandom_range(7) : i;
         wr(`PCT_OFF_CTRL, 32'h0);
         wr(`PCT_OFF_PSC, psc);
         wr(`PCT_OFF_ARR, 32'h4);
         wr(`PCT_OFF_CNT, 32'h0);
         hi = (i == 2) ? 4 : 5;
         tq.push_back(hi * (psc + 1));
         tq.push_back(hi * (psc + 1));
         wr(`PCT_OFF_CTRL, (i == 1) ? 32'h3 : (i == 2) ? 32'h5 : 32'h1);
         while (tq.size() != 0) @(posedge aclk);
      end
      // Interrupt raised, cleared, masked; single pulse
      wr(`PCT_OFF_CTRL, 32'h0);
      wr(`PCT_OFF_STAT, 32'h3F);
      rd(`PCT_OFF_STAT, 32'h0);
      wr(`PCT_OFF_MASK, 32'h1);
      wr(`PCT_OFF_CTRL, 32'h1);
      for (hi = 0; hi < 100 && irq !== 1'b1; hi++) @(posedge aclk);
      chk_pin(32'h1, {31'h0, irq});
      wr(`PCT_OFF_CTRL, 32'h0);
      wr(`PCT_OFF_STAT, 32'h1);
      @(posedge aclk);
      chk_pin(32'h0, {31'h0, irq});
      wr(`PCT_OFF_MASK, 32'h0);
      wr(`PCT_OFF_CNT, 32'h0);
      wr(`PCT_OFF_CTRL, 32'h9);
      for (hi = 0; hi < 100 && trg_out !== 1'b1; hi++) @(posedge aclk);
      repeat (3) @(posedge aclk);
      chk_pin(32'h0, {31'h0, irq});
      rd(`PCT_OFF_CTRL, 32'h8);
      rd(`PCT_OFF_CNT, 32'h0);
      rd(`PCT_OFF_STAT, 32'h1F);
      // Complementary pair with dead-time
      wr(`PCT_OFF_PSC, 32'h0);
      wr(`PCT_OFF_ARR, 32'h13);
      wr(`PCT_OFF_CCR0, 32'hA);
      wr(`PCT_OFF_DT, 32'h3);
      wr(`PCT_OFF_CHCFG, 32'h11);
      wr(`PCT_OFF_CTRL, 32'h1);
      repeat (40) @(posedge aclk);
      {hi, lo} = '0;
      repeat (20) begin
         @(posedge aclk);
         hi += ch_out[0];
         lo += chn_out[0];
      end
      chk_pin(32'h6, hi);
      chk_pin(32'h6, lo);
      chk_pin(32'h3, {30'h0, ch_oe[0], chn_oe[0]});
      // Pulse width from two captures
      wr(`PCT_OFF_CTRL, 32'h0);
      wr(`PCT_OFF_CHCFG, 32'h3);
      wr(`PCT_OFF_ARR, 32'hFFFF);
      wr(`PCT_OFF_CNT, 32'h0);
      wr(`PCT_OFF_STAT, 32'h3F);
      wr(`PCT_OFF_CTRL, 32'h1);
      w = 100 + $urandom_range(63);
      fork
         pm.pulse(w);
         begin
            repeat (20) @(posedge aclk);
            rd(`PCT_OFF_CCR0, 32'h0, 2'h0, 1'b1);
            lo = rdv;
            wr(`PCT_OFF_CHCFG, 32'h7);
         end
      join
      repeat (10) @(posedge aclk);
      rd(`PCT_OFF_CCR0, 32'h0, 2'h0, 1'b1);
      chk_pin(w, rdv - lo);
      rd(`PCT_OFF_STAT, 32'h1E);
      // Quadrature decoding both ways
      wr(`PCT_OFF_CTRL, 32'h0);
      wr(`PCT_OFF_CHCFG, 32'h303);
      wr(`PCT_OFF_SMODE, 32'h6);
      wr(`PCT_OFF_CNT, 32'h64);
      wr(`PCT_OFF_CTRL, 32'h1);
      pm.quad(8, 1'b0);
      pm.quad(3, 1'b1);
      repeat (8) @(posedge aclk);
      rd(`PCT_OFF_CNT, 32'h69);
      rd(`PCT_OFF_CTRL, 32'h101);
      // Counting trigger edges, then gated counting on the trigger level, then start on the trigger pin
      wr(`PCT_OFF_CTRL, 32'h0);
      wr(`PCT_OFF_SMODE, 32'hA);
      wr(`PCT_OFF_CNT, 32'h0);
      wr(`PCT_OFF_CTRL, 32'h1);
      repeat (5) begin
         trg_in <= 1'b1;
         repeat (3) @(posedge aclk);
         trg_in <= 1'b0;
         repeat (3) @(posedge aclk);
      end
      rd(`PCT_OFF_CNT, 32'h5);
      wr(`PCT_OFF_SMODE, 32'hB);
      trg_in <= 1'b1;
      repeat (12) @(posedge aclk);
      trg_in <= 1'b0;
      rd(`PCT_OFF_CNT, 32'h11);
      wr(`PCT_OFF_CTRL, 32'h0);
      wr(`PCT_OFF_SMODE, 32'h1);
      pm.kick();
      repeat (8) @(posedge aclk);
      rd(`PCT_OFF_CTRL, 32'h1);
      close_out();
   end
endmodule : pct_timer_tb
`default_nettype wire
